// >>> inc/pirq_params.svh
// offsets, field positions, reset values and masks of the flag block
`ifndef PIRQ_PARAMS_SVH
`define PIRQ_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define PIRQ_ADDR_W          12
`define PIRQ_ADDR_FLAGS      12'h00c
`define PIRQ_ADDR_ENABLES    12'h010
`define PIRQ_ADDR_CORE_CTRL  12'h014
`define PIRQ_ADDR_OVR_STAT   12'h018
`define PIRQ_ADDR_OVR_MASK   12'h01c

// ----------------------------------------------------------------------
// flag and enable bit positions
// ----------------------------------------------------------------------
`define PIRQ_BIT_CONV        6
`define PIRQ_BIT_SERIAL      3
`define PIRQ_BIT_CCP         2
`define PIRQ_BIT_PERIOD      1
`define PIRQ_BIT_WIDE        0
`define PIRQ_IMPL_MASK       8'h4f

// ----------------------------------------------------------------------
// core control bit positions
// ----------------------------------------------------------------------
`define PIRQ_BIT_GLOBAL_EN   7
`define PIRQ_BIT_PERIPH_EN   6
`define PIRQ_CORE_MASK       8'hc0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PIRQ_RST_FLAGS       8'h00
`define PIRQ_RST_ENABLES     8'h00
`define PIRQ_RST_CORE        8'h00
`define PIRQ_RST_OVR         8'h00

`endif

// >>> inc/pirq_pkg.sv
// types shared by the peripheral flag block
package pirq_pkg;

    typedef enum logic [2:0] {
        SEL_NONE      = 3'b000,
        SEL_FLAGS     = 3'b001,
        SEL_ENABLES   = 3'b010,
        SEL_CORE_CTRL = 3'b011,
        SEL_OVR_STAT  = 3'b100,
        SEL_OVR_MASK  = 3'b101
    } reg_sel_t;

    typedef enum logic [1:0] {
        CCP_OFF     = 2'b00,
        CCP_CAPTURE = 2'b01,
        CCP_COMPARE = 2'b10,
        CCP_PWM     = 2'b11
    } ccp_mode_t;

endpackage : pirq_pkg

// >>> inc/flag_bank_if.sv
// carrier between the flag block control logic and its flag bank
`timescale 1ns/10ps

interface flag_bank_if;
    logic [7:0] set_evt;
    logic       wr_en;
    logic [7:0] wr_data;
    logic [7:0] flags;

    modport ctrl (
        output set_evt,
        output wr_en,
        output wr_data,
        input  flags
    );

    modport bank (
        input  set_evt,
        input  wr_en,
        input  wr_data,
        output flags
    );
endinterface : flag_bank_if

// >>> rtl/flag_bank.sv
// sticky peripheral flag bits with set-over-clear priority
`timescale 1ns/10ps
`include "pirq_params.svh"

module flag_bank (
    input  wire logic   i_ref_clk,
    input  wire logic   i_arst_n,
    flag_bank_if.bank   fb
);

    localparam logic [7:0] IMPL = `PIRQ_IMPL_MASK;
    localparam logic [7:0] RST  = `PIRQ_RST_FLAGS;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            if (IMPL[gi]) begin : g_impl
                logic flag_q;
                logic flag_d;

                always_comb begin
                    flag_d = flag_q;
                    if (fb.wr_en) begin
                        flag_d = fb.wr_data[gi];
                    end
                    if (fb.set_evt[gi]) begin
                        flag_d = 1'b1;
                    end
                end

                always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
                    if (!i_arst_n) begin
                        flag_q <= RST[gi];
                    end else begin
                        flag_q <= flag_d;
                    end
                end

                assign fb.flags[gi] = flag_q;
            end else begin : g_unimpl
                assign fb.flags[gi] = 1'b0;
            end
        end
    endgenerate

endmodule : flag_bank

// >>> rtl/periph_irq_flags.sv
// peripheral interrupt flag register with enables and apb access
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "pirq_params.svh"

module periph_irq_flags (
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_conv_done,
    input  wire logic        i_serial_done,
    input  wire logic        i_ccp_capture,
    input  wire logic        i_ccp_compare,
    input  wire logic [1:0]  i_ccp_mode,
    input  wire logic        i_period_match,
    input  wire logic        i_wide_timer_overflow,
    output logic      [7:0]  o_peripheral_irq_flags,
    output logic             o_periph_irq_req,
    output logic             o_irq
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam logic [7:0] IMPL_MASK = `PIRQ_IMPL_MASK;
    localparam logic [7:0] CORE_MASK = `PIRQ_CORE_MASK;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic pirq_pkg::reg_sel_t decode_addr(
        input logic [11:0] addr
    );
        pirq_pkg::reg_sel_t sel;
        sel = pirq_pkg::SEL_NONE;
        if (addr == `PIRQ_ADDR_FLAGS) begin
            sel = pirq_pkg::SEL_FLAGS;
        end else if (addr == `PIRQ_ADDR_ENABLES) begin
            sel = pirq_pkg::SEL_ENABLES;
        end else if (addr == `PIRQ_ADDR_CORE_CTRL) begin
            sel = pirq_pkg::SEL_CORE_CTRL;
        end else if (addr == `PIRQ_ADDR_OVR_STAT) begin
            sel = pirq_pkg::SEL_OVR_STAT;
        end else if (addr == `PIRQ_ADDR_OVR_MASK) begin
            sel = pirq_pkg::SEL_OVR_MASK;
        end else begin
            sel = pirq_pkg::SEL_NONE;
        end
        return sel;
    endfunction : decode_addr

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    flag_bank_if           fb ();
    pirq_pkg::reg_sel_t    sel;
    pirq_pkg::ccp_mode_t   ccp_mode;
    logic                  setup_phase;
    logic                  access_phase;
    logic                  wr_fire;
    logic                  lane0;
    logic [7:0]            wbyte;
    logic [7:0]            events;
    logic [7:0]            flags;
    logic [7:0]            enables_q;
    logic [7:0]            enables_d;
    logic [7:0]            core_q;
    logic [7:0]            core_d;
    logic [7:0]            ovr_q;
    logic [7:0]            ovr_d;
    logic [7:0]            ovr_mask_q;
    logic [7:0]            ovr_mask_d;
    logic [31:0]           prdata_q;
    logic [31:0]           prdata_d;
    logic                  pslverr_q;
    logic                  pslverr_d;
    logic [7:0]            rd_byte;
    logic                  periph_pending;
    logic                  ovr_pending;
    logic                  flags_wr;

    // ------------------------------------------------------------------
    // apb phase tracking
    // ------------------------------------------------------------------
    assign setup_phase  = i_psel & ~i_penable;
    assign access_phase = i_psel & i_penable;
    assign sel          = decode_addr(i_paddr);
    assign lane0        = i_pstrb[0];
    assign wbyte        = i_pwdata[7:0];
    // writes land only at the access edge, zero wait states
    assign wr_fire      = access_phase & i_pwrite & lane0;
    assign o_pready     = access_phase;
    assign o_pslverr    = access_phase & pslverr_q;
    assign o_prdata     = prdata_q;

    // ------------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------------
    assign ccp_mode = pirq_pkg::ccp_mode_t'(i_ccp_mode);

    always_comb begin
        events = 8'h00;
        events[`PIRQ_BIT_CONV]   = i_conv_done;
        events[`PIRQ_BIT_SERIAL] = i_serial_done;
        case (ccp_mode)
            pirq_pkg::CCP_CAPTURE: begin
                events[`PIRQ_BIT_CCP] = i_ccp_capture;
            end
            pirq_pkg::CCP_COMPARE: begin
                events[`PIRQ_BIT_CCP] = i_ccp_compare;
            end
            default: begin
                events[`PIRQ_BIT_CCP] = 1'b0;
            end
        endcase
        events[`PIRQ_BIT_PERIOD] = i_period_match;
        events[`PIRQ_BIT_WIDE]   = i_wide_timer_overflow;
    end

    // ------------------------------------------------------------------
    // flag bank
    // ------------------------------------------------------------------
    assign flags_wr    = wr_fire & (sel == pirq_pkg::SEL_FLAGS);
    assign fb.set_evt  = events;
    assign fb.wr_en    = flags_wr;
    assign fb.wr_data  = wbyte & IMPL_MASK;
    assign flags       = fb.flags;

    flag_bank u_flag_bank (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .fb        (fb.bank)
    );

    // ------------------------------------------------------------------
    // control registers, next values
    // ------------------------------------------------------------------
    always_comb begin
        enables_d  = enables_q;
        core_d     = core_q;
        ovr_mask_d = ovr_mask_q;
        if (wr_fire) begin
            if (sel == pirq_pkg::SEL_ENABLES) begin
                enables_d = wbyte & IMPL_MASK;
            end else if (sel == pirq_pkg::SEL_CORE_CTRL) begin
                core_d = wbyte & CORE_MASK;
            end else if (sel == pirq_pkg::SEL_OVR_MASK) begin
                ovr_mask_d = wbyte & IMPL_MASK;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            enables_q  <= `PIRQ_RST_ENABLES;
            core_q     <= `PIRQ_RST_CORE;
            ovr_mask_q <= `PIRQ_RST_OVR;
        end else begin
            enables_q  <= enables_d;
            core_q     <= core_d;
            ovr_mask_q <= ovr_mask_d;
        end
    end

    // ------------------------------------------------------------------
    // overrun status: event while its flag was still pending
    // ------------------------------------------------------------------
    always_comb begin
        ovr_d = ovr_q;
        if (wr_fire && (sel == pirq_pkg::SEL_OVR_STAT)) begin
            ovr_d = ovr_q & ~wbyte;
        end
        // a new overrun beats a clear
        ovr_d = ovr_d | (events & flags & IMPL_MASK);
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ovr_q <= `PIRQ_RST_OVR;
        end else begin
            ovr_q <= ovr_d;
        end
    end

    // ------------------------------------------------------------------
    // read path, loaded in the setup cycle
    // ------------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (sel == pirq_pkg::SEL_FLAGS) begin
            rd_byte = flags & IMPL_MASK;
        end else if (sel == pirq_pkg::SEL_ENABLES) begin
            rd_byte = enables_q;
        end else if (sel == pirq_pkg::SEL_CORE_CTRL) begin
            rd_byte = core_q;
        end else if (sel == pirq_pkg::SEL_OVR_STAT) begin
            rd_byte = ovr_q;
        end else if (sel == pirq_pkg::SEL_OVR_MASK) begin
            rd_byte = ovr_mask_q;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_comb begin
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (setup_phase) begin
            pslverr_d = (sel == pirq_pkg::SEL_NONE);
            if (i_pwrite) begin
                prdata_d = 32'h0000_0000;
            end else begin
                prdata_d = {24'h00_0000, rd_byte};
            end
        end else if (!i_psel) begin
            pslverr_d = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------
    // flag, enable and peripheral enable
    assign periph_pending   = |(flags & enables_q & IMPL_MASK);
    assign o_periph_irq_req = periph_pending &
                              core_q[`PIRQ_BIT_PERIPH_EN];
    assign ovr_pending      = |(ovr_q & ovr_mask_q);
    // global enable gates o_irq only, for peripheral and overrun requests alike
    assign o_irq            = core_q[`PIRQ_BIT_GLOBAL_EN] &
                              (o_periph_irq_req | ovr_pending);

    // ------------------------------------------------------------------
    // flag state to the core
    // ------------------------------------------------------------------
    assign o_peripheral_irq_flags = flags;

endmodule : periph_irq_flags

// >>> dv/pirq_asserts.sv
// concurrent checks on the flag block ports
`timescale 1ns/10ps

module pirq_chk (
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    input  wire logic        o_pready,
    input  wire logic        i_conv_done,
    input  wire logic        i_serial_done,
    input  wire logic        i_ccp_capture,
    input  wire logic        i_ccp_compare,
    input  wire logic [1:0]  i_ccp_mode,
    input  wire logic        i_period_match,
    input  wire logic        i_wide_timer_overflow,
    input  wire logic [7:0]  o_peripheral_irq_flags,
    input  wire logic        o_periph_irq_req
);
    logic       wr;
    logic [7:0] f;
    logic [7:0] m;
    // -----------------------------------------------------------------
    // flag write strobe and qualified event vector
    // -----------------------------------------------------------------
    assign wr = i_psel & i_penable & i_pwrite & i_pstrb[0]
        & (i_paddr == 12'h00c);
    assign f = o_peripheral_irq_flags;
    assign m = {1'b0, i_conv_done, 2'b00, i_serial_done,
        (i_ccp_capture & (i_ccp_mode == 2'h1))
        | (i_ccp_compare & (i_ccp_mode == 2'h2)),
        i_period_match, i_wide_timer_overflow};
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    property p_evt; m != 8'h00 |=> (f & $past(m)) == $past(m); endproperty
    a_evt: assert property (p_evt)
        else $error("event did not set its flag");
    property p_pwm;
        !wr && !f[2] && (i_ccp_mode inside {2'h0, 2'h3}) |=> !f[2];
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("capture flag set outside capture or compare");
    property p_unimpl; (f & 8'hb0) == 8'h00; endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented flag bit set");
    property p_sticky; !wr |=> (f & $past(f)) == $past(f); endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a write");
    property p_write;
        wr && m == 8'h00 |=> f == ($past(i_pwdata[7:0]) & 8'h4f);
    endproperty
    a_write: assert property (p_write)
        else $error("flag write not taken");
    property p_race;
        wr && !i_pwdata[0] && i_wide_timer_overflow |=> f[0];
    endproperty
    a_race: assert property (p_race)
        else $error("event lost against clear");
    property p_req; o_periph_irq_req |-> f != 8'h00; endproperty
    a_req: assert property (p_req)
        else $error("request without a flag");
    property p_ready; i_psel && i_penable |-> o_pready; endproperty
    a_ready: assert property (p_ready)
        else $error("access phase without ready");
    c_evt: cover property (m != 8'h00);
    c_wr: cover property (wr);
    c_req: cover property (o_periph_irq_req);
endmodule : pirq_chk

bind periph_irq_flags pirq_chk u_chk (
    .i_ref_clk              (i_ref_clk),
    .i_arst_n               (i_arst_n),
    .i_psel                 (i_psel),
    .i_penable              (i_penable),
    .i_pwrite               (i_pwrite),
    .i_paddr                (i_paddr),
    .i_pwdata               (i_pwdata),
    .i_pstrb                (i_pstrb),
    .o_pready               (o_pready),
    .i_conv_done            (i_conv_done),
    .i_serial_done          (i_serial_done),
    .i_ccp_capture          (i_ccp_capture),
    .i_ccp_compare          (i_ccp_compare),
    .i_ccp_mode             (i_ccp_mode),
    .i_period_match         (i_period_match),
    .i_wide_timer_overflow  (i_wide_timer_overflow),
    .o_peripheral_irq_flags (o_peripheral_irq_flags),
    .o_periph_irq_req       (o_periph_irq_req)
);

// >>> dv/periph_evt_model.sv
// peripheral side model issuing one-cycle event strobes
`timescale 1ns/10ps

module periph_evt_model (
    input  wire logic       i_ref_clk,
    output logic      [5:0] o_evt
);
    // bits: conv, serial, capture, compare, period, wide
    initial o_evt = 6'h00;
    task automatic pulse(input logic [5:0] msk);
        @(posedge i_ref_clk);
        o_evt <= msk;
        @(posedge i_ref_clk);
        o_evt <= 6'h00;
    endtask : pulse
endmodule : periph_evt_model

// >>> dv/testbench.sv
// self-checking bench for the peripheral flag block
`timescale 1ns/10ps
`include "pirq_params.svh"

module testbench;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel  = 1'b0;
    logic        pen   = 1'b0;
    logic        pwr   = 1'b0;
    logic [11:0] addr  = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  strb  = 4'hf;
    logic [1:0]  mode  = 2'h0;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic        ready;
    logic        err;
    logic        er;
    logic        req;
    logic        irq;
    logic [7:0]  flags;
    logic [5:0]  evt;
    int          n_mismatch = 0;
    int          checked = 0;
    typedef struct packed {
        logic [5:0] ev;
        logic [1:0] md;
        logic [7:0] ex;
    } row_t;
    row_t rows [9] = '{{6'h20, 2'h0, 8'h40}, {6'h10, 2'h0, 8'h08},
        {6'h08, 2'h1, 8'h04}, {6'h04, 2'h2, 8'h04},
        {6'h04, 2'h3, 8'h00}, {6'h08, 2'h2, 8'h00},
        {6'h08, 2'h0, 8'h00}, {6'h02, 2'h0, 8'h02},
        {6'h01, 2'h0, 8'h01}};

    periph_irq_flags uut (.i_ref_clk(clk), .i_arst_n(rst_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
        .i_pwdata(wdata), .i_pstrb(strb), .o_prdata(rdata),
        .o_pready(ready), .o_pslverr(err), .i_conv_done(evt[5]),
        .i_serial_done(evt[4]), .i_ccp_capture(evt[3]),
        .i_ccp_compare(evt[2]), .i_ccp_mode(mode),
        .i_period_match(evt[1]), .i_wide_timer_overflow(evt[0]),
        .o_peripheral_irq_flags(flags), .o_periph_irq_req(req),
        .o_irq(irq));
    periph_evt_model evm (.i_ref_clk(clk), .o_evt(evt));

    initial forever #2 clk = ~clk;
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // -----------------------------------------------------------------
    // apb transfer, held until ready is sampled high
    // -----------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s = 4'hf);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        strb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (ready !== 1'b1);
        rd = rdata;
        er = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic chk_irq(input logic [31:0] exp);
        #1;
        chk({30'h0, req, irq}, exp);
    endtask : chk_irq
    task automatic complete_run;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        @(posedge rst_n);
        apb(1'b0, `PIRQ_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h0);
        apb(1'b1, `PIRQ_ADDR_FLAGS, 32'h000000ff);
        apb(1'b1, `PIRQ_ADDR_FLAGS, 32'h0, 4'h0);
        apb(1'b0, `PIRQ_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0000004f);
        apb(1'b1, `PIRQ_ADDR_FLAGS, 32'h0);
        foreach (rows[i]) begin
            mode <= rows[i].md;
            evm.pulse(rows[i].ev);
            repeat (4) @(posedge clk);
            chk({24'h0, flags}, {24'h0, rows[i].ex});
            apb(1'b0, `PIRQ_ADDR_FLAGS, 32'h0);
            chk(rd, {24'h0, rows[i].ex});
            apb(1'b1, `PIRQ_ADDR_FLAGS, 32'h0);
        end
        // enable only with the flag clear
        apb(1'b1, `PIRQ_ADDR_ENABLES, 32'h01);
        apb(1'b1, `PIRQ_ADDR_CORE_CTRL, 32'h000000c0);
        chk_irq(32'h0);
        evm.pulse(6'h01);
        repeat (20) @(posedge clk);
        chk_irq(32'h3);
        apb(1'b1, `PIRQ_ADDR_CORE_CTRL, 32'h00000080);
        chk_irq(32'h0);
        apb(1'b1, `PIRQ_ADDR_CORE_CTRL, 32'h000000c0);
        apb(1'b1, `PIRQ_ADDR_ENABLES, 32'h0);
        chk_irq(32'h0);
        apb(1'b1, `PIRQ_ADDR_ENABLES, 32'h01);
        chk_irq(32'h3);
        apb(1'b1, `PIRQ_ADDR_FLAGS, 32'h0);
        chk_irq(32'h0);
        fork
            apb(1'b1, `PIRQ_ADDR_FLAGS, 32'h0);
            begin
                @(posedge clk);
                evm.pulse(6'h01);
            end
        join
        apb(1'b0, `PIRQ_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h1);
        // overrun: second event while the flag is still pending
        evm.pulse(6'h01);
        apb(1'b0, `PIRQ_ADDR_OVR_STAT, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `PIRQ_ADDR_OVR_MASK, 32'h01);
        apb(1'b1, `PIRQ_ADDR_CORE_CTRL, 32'h000000ff);
        apb(1'b0, `PIRQ_ADDR_CORE_CTRL, 32'h0);
        chk(rd, 32'h000000c0);
        apb(1'b1, `PIRQ_ADDR_CORE_CTRL, 32'h00000080);
        chk_irq(32'h1);
        apb(1'b1, `PIRQ_ADDR_OVR_STAT, 32'h01);
        apb(1'b0, `PIRQ_ADDR_OVR_STAT, 32'h0);
        chk(rd, 32'h0);
        chk_irq(32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `PIRQ_ADDR_FLAGS, 32'h0000004f);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({24'h0, flags}, 32'h0);
        chk({30'h0, req, irq}, 32'h0);
        rst_n <= 1'b1;
        apb(1'b0, `PIRQ_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PIRQ_ADDR_ENABLES, 32'h0);
        chk(rd, 32'h0);
        complete_run();
    end
endmodule : testbench
